// ### design/htf_pkg.sv
// package for the hardware trap flag unit
package htf_pkg;
  localparam logic [31:0] FLAG_OFFSET     = 32'h0000_ffac;
  localparam logic [31:0] LIMIT_OV_OFFSET = 32'h0000_ffb0;
  localparam logic [31:0] LIMIT_UN_OFFSET = 32'h0000_ffb4;
  localparam logic [31:0] STATUS_OFFSET   = 32'h0000_ffb8;
  localparam logic [15:0] FLAG_RESET      = 16'h0000;
  localparam logic [15:0] LIMIT_RESET     = 16'h0000;
  localparam logic [15:0] FLAG_MASK       = 16'he08f;
  localparam int BIT_NMI   = 15;
  localparam int BIT_OVF   = 14;
  localparam int BIT_UNF   = 13;
  localparam int BIT_UNDEF = 7;
  localparam int BIT_PROT  = 3;
  localparam int BIT_ODDOP = 2;
  localparam int BIT_ODDIT = 1;
  localparam int BIT_NOBUS = 0;
  localparam logic [3:0]  PRIO_TRAP = 4'hf;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0]  HSIZE_WORD    = 3'b010;
  localparam logic [23:0] VEC_NMI   = 24'h00_0008;
  localparam logic [23:0] VEC_OVF   = 24'h00_0010;
  localparam logic [23:0] VEC_UNF   = 24'h00_0018;
  localparam logic [23:0] VEC_CLSB  = 24'h00_0028;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_CLSB = 3'b010,
    ST_CLSA = 3'b100
  } htf_state_t;

  // overflow/underflow cause selects pushed pointer
  typedef enum logic [1:0] {
    SPC_IMPLICIT = 2'b00,
    SPC_ARITH    = 2'b01
  } htf_spcause_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] sp_new;
    logic        dec;
    logic        inc;
    htf_spcause_t cause;
  } htf_sp_t;

  typedef struct packed {
    logic        bus_ext;
    logic        bus_defined;
    logic        branch;
    logic [23:0] branch_tgt;
    logic        word_acc;
    logic [23:0] oper_addr;
    logic        prot_bad;
    logic        undef_op;
  } htf_fault_t;

  typedef struct packed {
    logic [23:0] cur;
    logic [23:0] next;
    logic [23:0] next2;
  } htf_ip_t;

  typedef struct packed {
    logic        take;
    logic        class_a;
    logic [23:0] vector;
    logic [23:0] push_ip;
    logic        push_seg;
    logic        repush;
    logic [3:0]  level;
  } htf_entry_t;
endpackage : htf_pkg

// ### design/htf_trap_unit.sv
// hardware trap flag register, ranking and trap entry selection
`timescale 1ns/10ps
module htf_trap_unit
  import htf_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // external non-maskable interrupt pin
  input  wire logic        nmi_n_i,
  // core side
  input  wire htf_sp_t     sp_i,
  input  wire htf_fault_t  fault_i,
  input  wire htf_ip_t     ip_i,
  input  wire logic        segmented_i,
  input  wire logic        entry_ack_i,
  input  wire logic        int_return_i,
  output htf_entry_t       entry_o,
  output logic [2:0]       state_o
);

  logic [15:0] trap_flag_register;
  logic [15:0] stack_overflow_limit;
  logic [15:0] stack_underflow_limit;
  logic [2:0]  nmi_sync;
  logic        nmi_level;
  logic [15:0] hw_set;
  logic        odd_target;
  logic        odd_oper;
  logic        ovf_hit;
  logic        unf_hit;
  logic        wr_pend;
  logic        rd_pend;
  logic [31:0] addr_q;
  logic        wr_flags;
  logic [15:0] sw_val;
  htf_state_t  state;
  htf_state_t  next_state;
  logic        outer_b;
  logic        b_deferred;
  logic [23:0] saved_ip;
  logic [23:0] ovf_ip;
  logic [23:0] unf_ip;
  logic        a_pend;
  logic        b_pend;
  htf_entry_t  next_entry;

  // nmi pin through three flops; edge counted when stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nmi_sync <= 3'b111;
    end else begin
      nmi_sync <= {nmi_sync[1:0], nmi_n_i};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nmi_level <= 1'b1;
    end else if (nmi_sync[1] == nmi_sync[2]) begin
      nmi_level <= nmi_sync[2];
    end
  end

  assign odd_target = fault_i.branch & fault_i.branch_tgt[0];
  assign odd_oper   = fault_i.word_acc & fault_i.oper_addr[0];
  assign ovf_hit = sp_i.valid & sp_i.dec
                 & (sp_i.sp_new < stack_overflow_limit);
  assign unf_hit = sp_i.valid & sp_i.inc
                 & (sp_i.sp_new > stack_underflow_limit);

  always_comb begin
    hw_set            = '0;
    hw_set[BIT_NMI]   = nmi_level & (nmi_sync[1] == nmi_sync[2])
                      & ~nmi_sync[2];
    hw_set[BIT_OVF]   = ovf_hit;
    hw_set[BIT_UNF]   = unf_hit;
    hw_set[BIT_UNDEF] = fault_i.undef_op;
    hw_set[BIT_PROT]  = fault_i.prot_bad;
    hw_set[BIT_ODDOP] = odd_oper;
    hw_set[BIT_ODDIT] = odd_target;
    hw_set[BIT_NOBUS] = fault_i.bus_ext & ~fault_i.bus_defined;
  end

  // ahb address phase capture; zero wait states
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= '0;
    end else if (hready_i) begin
      wr_pend <= hsel_i & (htrans_i == HTRANS_NONSEQ) & hwrite_i
               & (hsize_i == HSIZE_WORD);
      rd_pend <= hsel_i & (htrans_i == HTRANS_NONSEQ) & ~hwrite_i;
      addr_q  <= haddr_i;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign wr_flags = wr_pend & (addr_q == FLAG_OFFSET);
  assign sw_val   = hwdata_i[15:0] & FLAG_MASK;

  // flags: sticky, software writes value, hardware set wins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trap_flag_register <= FLAG_RESET;
    end else if (wr_flags) begin
      trap_flag_register <= sw_val | hw_set;
    end else begin
      trap_flag_register <= trap_flag_register | hw_set;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stack_overflow_limit  <= LIMIT_RESET;
      stack_underflow_limit <= LIMIT_RESET;
    end else if (wr_pend) begin
      if (addr_q == LIMIT_OV_OFFSET) begin
        stack_overflow_limit <= hwdata_i[15:0];
      end
      if (addr_q == LIMIT_UN_OFFSET) begin
        stack_underflow_limit <= hwdata_i[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
    end else if (hready_i & hsel_i & (htrans_i == HTRANS_NONSEQ)
                 & ~hwrite_i) begin
      case (haddr_i)
        FLAG_OFFSET:     hrdata_o <= {16'h0000, trap_flag_register};
        LIMIT_OV_OFFSET: hrdata_o <= {16'h0000, stack_overflow_limit};
        LIMIT_UN_OFFSET: hrdata_o <= {16'h0000, stack_underflow_limit};
        STATUS_OFFSET:   hrdata_o <= {29'h0000_0000, state};
        default:         hrdata_o <= '0;
      endcase
    end
  end

  // pending requests come from the flags, so soft-set flags act alike
  assign a_pend = trap_flag_register[BIT_NMI] | trap_flag_register[BIT_OVF]
                | trap_flag_register[BIT_UNF];
  assign b_pend = trap_flag_register[BIT_UNDEF] | trap_flag_register[BIT_PROT]
                | trap_flag_register[BIT_ODDOP]
                | trap_flag_register[BIT_ODDIT]
                | trap_flag_register[BIT_NOBUS];

  // pointers for stack traps
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ovf_ip <= '0;
      unf_ip <= '0;
    end else begin
      if (ovf_hit) begin
        ovf_ip <= (sp_i.cause == SPC_ARITH) ? ip_i.next2 : ip_i.next;
      end
      if (unf_hit) begin
        unf_ip <= (sp_i.cause == SPC_ARITH) ? ip_i.next2 : ip_i.next;
      end
    end
  end

  // class B pointer kept for re-push; next pointer stored if raised in class A handler
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      saved_ip <= '0;
    end else if (state != ST_CLSA) begin
      if (fault_i.undef_op | fault_i.prot_bad) begin
        saved_ip <= ip_i.cur;
      end else if (odd_target) begin
        saved_ip <= fault_i.branch_tgt;
      end else if (|hw_set[BIT_ODDOP:BIT_NOBUS]) begin
        saved_ip <= ip_i.next;
      end
    end else if (|hw_set[BIT_UNDEF:BIT_NOBUS]) begin
      saved_ip <= ip_i.next;
    end
  end

  always_comb begin
    next_entry         = '0;
    next_entry.level   = PRIO_TRAP;
    next_entry.push_seg = segmented_i;
    if (a_pend & (state != ST_CLSA)) begin
      next_entry.take    = 1'b1;
      next_entry.class_a = 1'b1;
      if (trap_flag_register[BIT_NMI]) begin
        next_entry.vector  = VEC_NMI;
        // simultaneous class B fault in run state: its pointer goes on the stack
        next_entry.push_ip = (b_pend & (state == ST_RUN))
                           ? saved_ip : ip_i.next;
      end else if (trap_flag_register[BIT_OVF]) begin
        next_entry.vector  = VEC_OVF;
        next_entry.push_ip = ovf_ip;
      end else begin
        next_entry.vector  = VEC_UNF;
        next_entry.push_ip = unf_ip;
      end
    end else if (b_pend & (state == ST_RUN)) begin
      next_entry.take    = 1'b1;
      next_entry.vector  = VEC_CLSB;
      next_entry.push_ip = saved_ip;
      next_entry.repush  = b_deferred;
    end
  end

  assign entry_o = next_entry;
  assign state_o = state;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (entry_ack_i & next_entry.take) begin
          next_state = next_entry.class_a ? ST_CLSA : ST_CLSB;
        end
      end
      ST_CLSB: begin
        if (entry_ack_i & next_entry.take) begin
          next_state = ST_CLSA;
        end else if (int_return_i) begin
          next_state = ST_RUN;
        end
      end
      ST_CLSA: begin
        if (int_return_i) begin
          next_state = outer_b ? ST_CLSB : ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state   <= ST_RUN;
      outer_b <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_CLSB && next_state == ST_CLSA) begin
        outer_b <= 1'b1;
      end else if (next_state == ST_RUN || state == ST_CLSB) begin
        outer_b <= 1'b0;
      end
    end
  end

  // class B left pending under a class A entry from run: re-push later
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      b_deferred <= 1'b0;
    end else if (state == ST_RUN && next_state == ST_CLSA) begin
      b_deferred <= b_pend;
    end else if (!b_pend || (state == ST_RUN && next_state == ST_CLSB)) begin
      b_deferred <= 1'b0;
    end
  end

  // assertions
  a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!wr_flags && $past(!rst_i)) |=> ((trap_flag_register
      & $past(trap_flag_register)) == $past(trap_flag_register)))
    else $error("flag dropped without software write");
  a_hw_set_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (hw_set[BIT_UNDEF] && wr_flags) |=> trap_flag_register[BIT_UNDEF])
    else $error("hardware set lost to clear");
  a_unused_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (trap_flag_register & ~FLAG_MASK) == 16'h0000)
    else $error("unused flag bit set");
  a_nobus_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (fault_i.bus_ext && !fault_i.bus_defined)
      |=> trap_flag_register[BIT_NOBUS])
    else $error("no-bus flag not set");
  a_odd_target: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    odd_target |=> trap_flag_register[BIT_ODDIT])
    else $error("odd target flag not set");
  a_odd_oper: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    odd_oper |=> trap_flag_register[BIT_ODDOP])
    else $error("odd operand flag not set");
  a_prot_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fault_i.prot_bad |=> trap_flag_register[BIT_PROT])
    else $error("protection flag not set");
  a_ovf_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ovf_hit |=> trap_flag_register[BIT_OVF])
    else $error("overflow flag not set");
  a_unf_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    unf_hit |=> trap_flag_register[BIT_UNF])
    else $error("underflow flag not set");
  a_nmi_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (entry_o.take && trap_flag_register[BIT_NMI])
      |-> entry_o.vector == VEC_NMI)
    else $error("nmi not served first");
  a_no_b_in_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == ST_CLSA) |-> !entry_o.take)
    else $error("trap taken inside class A handler");
  a_a_preempts_b: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == ST_CLSB && a_pend) |-> (entry_o.take && entry_o.class_a))
    else $error("class A did not preempt class B");
  a_level_fifteen: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    entry_o.take |-> entry_o.level == PRIO_TRAP)
    else $error("trap level not fifteen");
  a_b_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (entry_o.take && !entry_o.class_a) |-> entry_o.vector == VEC_CLSB)
    else $error("class B vector wrong");
  a_nmi_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hw_set[BIT_NMI] |=> trap_flag_register[BIT_NMI])
    else $error("nmi flag not set");

  c_nmi_entry:  cover property (@(posedge clk_sys_i)
    entry_o.take && entry_o.vector == VEC_NMI);
  c_b_entry:    cover property (@(posedge clk_sys_i)
    entry_o.take && !entry_o.class_a);
  c_preempt:    cover property (@(posedge clk_sys_i)
    state == ST_CLSB ##1 state == ST_CLSA);
  c_repush:     cover property (@(posedge clk_sys_i) entry_o.repush);

endmodule : htf_trap_unit

// ### testbench/htf_core_model.sv
// core side model that acknowledges offered trap entries
`timescale 1ns/10ps
module htf_core_model
  import htf_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // control from bench
  input  wire logic       en_i,
  input  wire logic [3:0] dly_i,
  // entry handshake
  input  wire htf_entry_t entry_i,
  output logic            ack_o
);
  logic [3:0] cnt;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !en_i || !entry_i.take || ack_o) begin
      ack_o <= 1'b0;
      cnt   <= 4'h0;
    end else if (cnt >= dly_i) begin
      ack_o <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : htf_core_model

// ### testbench/testbench.sv
// self-checking bench for the trap flag unit
`timescale 1ns/10ps
module testbench;
  import htf_pkg::*;
  logic        clk_sys_i;
  logic        rst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  logic        nmi_n;
  htf_sp_t     sp;
  htf_fault_t  fault;
  htf_fault_t  f;
  htf_ip_t     ip;
  logic        seg;
  logic        ack;
  logic        int_ret;
  htf_entry_t  entry;
  logic [2:0]  state;
  logic        en;
  logic [3:0]  dly;
  logic [31:0] seed;
  logic [31:0] rdat;
  int          num_errors;
  int          tests_run;
  int          bits[8] = '{15, 14, 13, 7, 3, 2, 1, 0};
  int          hwb[5]  = '{128, 8, 4, 2, 1};
  localparam htf_fault_t F0 = '{bus_defined: 1'b1, default: '0};

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  htf_trap_unit u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .nmi_n_i(nmi_n), .sp_i(sp),
    .fault_i(fault), .ip_i(ip), .segmented_i(seg), .entry_ack_i(ack),
    .int_return_i(int_ret), .entry_o(entry), .state_o(state));

  htf_core_model u_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_i(en),
    .dly_i(dly), .entry_i(entry), .ack_o(ack));

  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  function automatic logic [23:0] vof(input int b);
    vof = (b == BIT_NMI) ? VEC_NMI : (b == BIT_OVF) ? VEC_OVF :
          (b == BIT_UNF) ? VEC_UNF : VEC_CLSB;
  endfunction : vof

  function automatic logic ok(input int m, input logic [2:0] s);
    if (m == 0) ok = (hrdy === 1'b1);
    else if (m == 1) ok = (entry.take === 1'b1 && entry.vector === VEC_NMI);
    else ok = (state === s);
  endfunction : ok

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wt(input int m, input logic [2:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!ok(m, s) && n < 40);
    if (n >= 40) begin
      num_errors++;
      $display("mismatch wait %0d expected done seen timeout", m);
      finish_test();
    end
  endtask : wt

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic hit);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    wt(0, 3'b000);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    fault.undef_op <= hit;
    wt(0, 3'b000);
    rdat = hrdata;
    fault.undef_op <= 1'b0;
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b0);
    chk("register", e, rdat);
  endtask : rd

  task automatic pf(input htf_fault_t v);
    fault <= v;
    @(posedge clk_sys_i);
    fault <= F0;
  endtask : pf

  task automatic ps(input logic d, input logic [15:0] v, input int c);
    sp <= '{valid: 1'b1, sp_new: v, dec: d, inc: ~d,
            cause: htf_spcause_t'(c)};
    @(posedge clk_sys_i);
    sp <= '0;
  endtask : ps

  task automatic rip;
    htf_ip_t v;
    seed = nx(seed);
    v.cur   = {seed[23:1], 1'b0};
    v.next  = v.cur + 24'h2;
    v.next2 = v.cur + 24'h4;
    ip  <= v;
    seg <= seed[31];
    @(posedge clk_sys_i);
  endtask : rip

  task automatic rt;
    int_ret <= 1'b1;
    @(posedge clk_sys_i);
    int_ret <= 1'b0;
  endtask : rt

  task automatic ce(input logic t, input logic [23:0] v,
                    input logic [23:0] p, input logic cp);
    @(posedge clk_sys_i);
    chk("take", 32'(t), 32'(entry.take));
    if (t) begin
      chk("vector", 32'(v), 32'(entry.vector));
      chk("level", 32'(PRIO_TRAP), 32'(entry.level));
      chk("push_seg", 32'(seg), 32'(entry.push_seg));
      if (cp) chk("push_ip", 32'(p), 32'(entry.push_ip));
    end
  endtask : ce

  task automatic clr;
    bus(1'b1, FLAG_OFFSET, 32'h0, 1'b0);
  endtask : clr

  initial begin
    num_errors = 0;
    tests_run  = 0;
    seed   = 32'h0001_1931;
    rst_i  = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b000;
    hwdata = 32'h0;
    nmi_n  = 1'b1;
    sp     = '0;
    fault  = F0;
    ip     = '0;
    seg    = 1'b0;
    int_ret = 1'b0;
    en     = 1'b0;
    dly    = 4'h1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(FLAG_OFFSET, 32'(FLAG_RESET));
    rd(32'h0000_ff00, 32'h0);
    rip();
    foreach (bits[i]) begin
      bus(1'b1, FLAG_OFFSET, 32'(1 << bits[i]), 1'b0);
      ce(1'b1, vof(bits[i]), 24'h0, 1'b0);
      rd(FLAG_OFFSET, 32'(1 << bits[i]));
      clr();
      ce(1'b0, 24'h0, 24'h0, 1'b0);
    end
    bus(1'b1, FLAG_OFFSET, 32'hffff_ffff, 1'b0);
    rd(FLAG_OFFSET, 32'(FLAG_MASK));
    ce(1'b1, VEC_NMI, 24'h0, 1'b0);
    bus(1'b1, FLAG_OFFSET, 32'h0000_6000, 1'b0);
    ce(1'b1, VEC_OVF, 24'h0, 1'b0);
    clr();
    $display("test software flags done");
    for (int k = 0; k < 5; k++) begin
      rip();
      f = F0;
      case (k)
        0: f.undef_op = 1'b1;
        1: f.prot_bad = 1'b1;
        2: begin
          f.word_acc  = 1'b1;
          f.oper_addr = seed[23:0] | 24'h1;
        end
        3: begin
          f.branch     = 1'b1;
          f.branch_tgt = seed[23:0] | 24'h1;
        end
        default: begin
          f.bus_ext     = 1'b1;
          f.bus_defined = 1'b0;
        end
      endcase
      pf(f);
      ce(1'b1, VEC_CLSB, ip.cur, k == 0);
      rd(FLAG_OFFSET, 32'(hwb[k]));
      clr();
    end
    f = '{word_acc: 1'b1, branch: 1'b1, bus_ext: 1'b1, bus_defined: 1'b1,
          branch_tgt: 24'h00_2000, oper_addr: 24'h00_1000, default: '0};
    pf(f);
    rd(FLAG_OFFSET, 32'h0);
    f = F0;
    f.undef_op = 1'b1;
    f.prot_bad = 1'b1;
    pf(f);
    ce(1'b1, VEC_CLSB, 24'h0, 1'b0);
    rd(FLAG_OFFSET, 32'h0000_0088);
    clr();
    $display("test class b faults done");
    bus(1'b1, LIMIT_OV_OFFSET, 32'h0000_0100, 1'b0);
    bus(1'b1, LIMIT_UN_OFFSET, 32'h0000_0200, 1'b0);
    rd(LIMIT_OV_OFFSET, 32'h0000_0100);
    ps(1'b1, 16'h0100, 1);
    ps(1'b0, 16'h0200, 1);
    rd(FLAG_OFFSET, 32'h0);
    for (int c = 0; c < 2; c++) begin
      rip();
      ps(1'b1, 16'h00fe, c);
      ce(1'b1, VEC_OVF, c ? ip.next2 : ip.next, 1'b1);
      rd(FLAG_OFFSET, 32'h0000_4000);
      clr();
      ps(1'b0, 16'h0202, c);
      ce(1'b1, VEC_UNF, c ? ip.next2 : ip.next, 1'b1);
      rd(FLAG_OFFSET, 32'h0000_2000);
      clr();
    end
    $display("test stack limits done");
    rip();
    nmi_n <= 1'b0;
    wt(1, 3'b000);
    ce(1'b1, VEC_NMI, ip.next, 1'b1);
    nmi_n <= 1'b1;
    rd(FLAG_OFFSET, 32'h0000_8000);
    clr();
    bus(1'b1, FLAG_OFFSET, 32'h0000_0004, 1'b0);
    en <= 1'b1;
    wt(2, ST_CLSB);
    en <= 1'b0;
    nmi_n <= 1'b0;
    wt(1, 3'b000);
    nmi_n <= 1'b1;
    en <= 1'b1;
    wt(2, ST_CLSA);
    en <= 1'b0;
    rip();
    f = F0;
    f.undef_op = 1'b1;
    pf(f);
    ce(1'b0, 24'h0, 24'h0, 1'b0);
    rd(FLAG_OFFSET, 32'h0000_8084);
    bus(1'b1, FLAG_OFFSET, 32'h0000_0084, 1'b0);
    rt();
    ce(1'b0, 24'h0, 24'h0, 1'b0);
    dly <= 4'h3;
    en  <= 1'b1;
    wt(2, ST_CLSB);
    en <= 1'b0;
    rt();
    ce(1'b1, VEC_CLSB, ip.next, 1'b1);
    clr();
    $display("test nesting done");
    rip();
    nmi_n <= 1'b0;
    pf(f);
    wt(1, 3'b000);
    ce(1'b1, VEC_NMI, ip.cur, 1'b1);
    nmi_n <= 1'b1;
    en    <= 1'b1;
    wt(2, ST_CLSA);
    en <= 1'b0;
    bus(1'b1, FLAG_OFFSET, 32'h0000_0080, 1'b0);
    rt();
    ce(1'b1, VEC_CLSB, ip.cur, 1'b1);
    chk("repush", 32'h1, 32'(entry.repush));
    clr();
    bus(1'b1, FLAG_OFFSET, 32'h0, 1'b1);
    rd(FLAG_OFFSET, 32'h0000_0080);
    $display("test undef with nmi done");
    finish_test();
  end
endmodule : testbench
